// *** hdl/rfsc_cal_regs.v ***
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rfsc_regs.vh"
module rfsc_cal_regs (
	input  wire                     aclk,
	input  wire                     aresetn,
	// ----------------------------------------
	// axi4-lite slave
	// ----------------------------------------
	input  wire [`RFSC_ADDR_W-1:0]  s_axi_awaddr,
	input  wire                     s_axi_awvalid,
	output wire                     s_axi_awready,
	input  wire [`RFSC_DATA_W-1:0]  s_axi_wdata,
	input  wire [3:0]               s_axi_wstrb,
	input  wire                     s_axi_wvalid,
	output wire                     s_axi_wready,
	output wire [1:0]               s_axi_bresp,
	output wire                     s_axi_bvalid,
	input  wire                     s_axi_bready,
	input  wire [`RFSC_ADDR_W-1:0]  s_axi_araddr,
	input  wire                     s_axi_arvalid,
	output wire                     s_axi_arready,
	output wire [`RFSC_DATA_W-1:0]  s_axi_rdata,
	output wire [1:0]               s_axi_rresp,
	output wire                     s_axi_rvalid,
	input  wire                     s_axi_rready,
	// ----------------------------------------
	// calibration engine and power manager
	// ----------------------------------------
	input  wire                     cal_done,
	input  wire [3:0]               cal_charge_pump_code,
	input  wire [4:0]               cal_vco_code,
	input  wire                     power_resume,
	input  wire [1:0]               power_resume_mode,
	// ----------------------------------------
	// analog trim outputs
	// ----------------------------------------
	output wire [1:0]               low_noise_amp_bias,
	output wire [1:0]               amp_to_mixer_bias,
	output wire [1:0]               rx_lo_buffer_bias,
	output wire [1:0]               mixer_bias,
	output wire [1:0]               tx_lo_buffer_bias,
	output wire [2:0]               tx_reserved_cfg,
	output wire [1:0]               synth_cal_config,
	output wire [1:0]               charge_pump_cal_enable,
	output wire                     charge_pump_stage_en,
	output wire [3:0]               charge_pump_code,
	output wire                     vco_high_select,
	output wire [4:0]               vco_current_code
);
	// ----------------------------------------
	// storage
	// ----------------------------------------
	reg  [7:0]              rx_front_end_config_reg;
	reg  [7:0]              rx_front_end_config_next;
	reg  [5:0]              tx_front_end_config_reg;
	reg  [5:0]              tx_front_end_config_next;
	reg  [7:0]              synth_charge_pump_cal_reg;
	reg  [7:0]              synth_charge_pump_cal_next;
	reg  [5:0]              synth_vco_cal_reg;
	reg  [5:0]              synth_vco_cal_next;
	// only bits 5:0 of these two words are stored
	localparam [7:0]        tx_rst_word  = `RFSC_RST_TX_FE;
	localparam [7:0]        vco_rst_word = `RFSC_RST_VCO_CAL;

	wire                    wr_en;
	wire [`RFSC_ADDR_W-1:0] wr_addr;
	wire [7:0]              wr_data;
	wire                    wr_strb;
	wire [`RFSC_ADDR_W-1:0] rd_addr;
	reg  [7:0]              rd_data;
	wire [2:0]              wr_dec;
	wire [2:0]              rd_dec;
	wire                    wr_hit;
	wire                    wr_go;
	wire                    deep_resume;
	wire                    cal_take_cp;

	// ----------------------------------------
	// address decode: {hit, select}
	// ----------------------------------------
	function [2:0] rfsc_decode;
		input [`RFSC_ADDR_W-1:0] a;
		begin
			if (a[1:0] != 2'b00)
				rfsc_decode = 3'b000;
			else if (a[`RFSC_ADDR_W-1:2] == `RFSC_IDX_RX_FE)
				rfsc_decode = {1'b1, `RFSC_SEL_RX_FE};
			else if (a[`RFSC_ADDR_W-1:2] == `RFSC_IDX_TX_FE)
				rfsc_decode = {1'b1, `RFSC_SEL_TX_FE};
			else if (a[`RFSC_ADDR_W-1:2] == `RFSC_IDX_CP_CAL)
				rfsc_decode = {1'b1, `RFSC_SEL_CP_CAL};
			else if (a[`RFSC_ADDR_W-1:2] == `RFSC_IDX_VCO_CAL)
				rfsc_decode = {1'b1, `RFSC_SEL_VCO_CAL};
			else
				rfsc_decode = 3'b000;
		end
	endfunction

	assign wr_dec = rfsc_decode(wr_addr);
	assign rd_dec = rfsc_decode(rd_addr);
	assign wr_hit = wr_dec[2];
	// byte lane 0 carries the 8-bit register
	assign wr_go  = wr_en && wr_hit && wr_strb;

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	rfsc_axil_slave u_slave (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_en         (wr_en),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_strb       (wr_strb),
		.wr_ok         (wr_hit),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data),
		.rd_ok         (rd_dec[2])
	);

	// ----------------------------------------
	// power and calibration events
	// ----------------------------------------
	assign deep_resume = power_resume &&
		((power_resume_mode == `RFSC_MODE_SLEEP_A) ||
		 (power_resume_mode == `RFSC_MODE_SLEEP_B));
	// stage skipped while its enable field is zero
	assign cal_take_cp = cal_done &&
		(synth_charge_pump_cal_reg[`RFSC_CP_EN_HI:`RFSC_CP_EN_LO] != 2'b00);

	// ----------------------------------------
	// front end configuration next values
	// ----------------------------------------
	always @* begin
		rx_front_end_config_next = rx_front_end_config_reg;
		if (wr_go && (wr_dec[1:0] == `RFSC_SEL_RX_FE))
			rx_front_end_config_next = wr_data;
	end

	always @* begin
		tx_front_end_config_next = tx_front_end_config_reg;
		if (wr_go && (wr_dec[1:0] == `RFSC_SEL_TX_FE)) begin
			// bits 7:6 and 3 are not stored
			tx_front_end_config_next[5:4] = wr_data[`RFSC_TX_LO_HI:`RFSC_TX_LO_LO];
			tx_front_end_config_next[3]   = 1'b0;
			tx_front_end_config_next[2:0] = wr_data[`RFSC_TX_RSV_HI:`RFSC_TX_RSV_LO];
		end
	end

	// ----------------------------------------
	// calibration register next values
	// ----------------------------------------
	always @* begin
		synth_charge_pump_cal_next = synth_charge_pump_cal_reg;
		if (wr_go && (wr_dec[1:0] == `RFSC_SEL_CP_CAL))
			synth_charge_pump_cal_next = wr_data;
		// engine result beats a software write in the same cycle
		if (cal_take_cp)
			synth_charge_pump_cal_next[`RFSC_CP_CODE_HI:`RFSC_CP_CODE_LO] =
				cal_charge_pump_code;
		if (deep_resume)
			synth_charge_pump_cal_next = `RFSC_RST_CP_CAL;
	end

	always @* begin
		synth_vco_cal_next = synth_vco_cal_reg;
		if (wr_go && (wr_dec[1:0] == `RFSC_SEL_VCO_CAL))
			synth_vco_cal_next = wr_data[5:0];
		if (cal_done)
			synth_vco_cal_next[`RFSC_VCO_CODE_HI:`RFSC_VCO_CODE_LO] = cal_vco_code;
		if (deep_resume)
			synth_vco_cal_next = vco_rst_word[5:0];
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			rx_front_end_config_reg   <= `RFSC_RST_RX_FE;
			tx_front_end_config_reg   <= tx_rst_word[5:0];
			synth_charge_pump_cal_reg <= `RFSC_RST_CP_CAL;
			synth_vco_cal_reg         <= vco_rst_word[5:0];
		end else begin
			rx_front_end_config_reg   <= rx_front_end_config_next;
			tx_front_end_config_reg   <= tx_front_end_config_next;
			synth_charge_pump_cal_reg <= synth_charge_pump_cal_next;
			synth_vco_cal_reg         <= synth_vco_cal_next;
		end
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always @* begin
		rd_data = 8'h00;
		if (rd_dec[2]) begin
			case (rd_dec[1:0])
				`RFSC_SEL_RX_FE: begin
					rd_data = rx_front_end_config_reg;
				end
				`RFSC_SEL_TX_FE: begin
					rd_data = {2'b00, tx_front_end_config_reg};
				end
				`RFSC_SEL_CP_CAL: begin
					rd_data = synth_charge_pump_cal_reg;
				end
				`RFSC_SEL_VCO_CAL: begin
					rd_data = {2'b00, synth_vco_cal_reg};
				end
				default: begin
					rd_data = 8'h00;
				end
			endcase
		end
	end

	// ----------------------------------------
	// trim outputs, straight from the stored bits; stage enable is decoded from the enable field
	// ----------------------------------------
	assign low_noise_amp_bias     = rx_front_end_config_reg[`RFSC_RX_LNA_HI:`RFSC_RX_LNA_LO];
	assign amp_to_mixer_bias      = rx_front_end_config_reg[`RFSC_RX_L2M_HI:`RFSC_RX_L2M_LO];
	assign rx_lo_buffer_bias      = rx_front_end_config_reg[`RFSC_RX_LO_HI:`RFSC_RX_LO_LO];
	assign mixer_bias             = rx_front_end_config_reg[`RFSC_RX_MIX_HI:`RFSC_RX_MIX_LO];
	assign tx_lo_buffer_bias      = tx_front_end_config_reg[`RFSC_TX_LO_HI:`RFSC_TX_LO_LO];
	assign tx_reserved_cfg        = tx_front_end_config_reg[`RFSC_TX_RSV_HI:`RFSC_TX_RSV_LO];
	assign synth_cal_config       = synth_charge_pump_cal_reg[`RFSC_CP_CFG_HI:`RFSC_CP_CFG_LO];
	assign charge_pump_cal_enable = synth_charge_pump_cal_reg[`RFSC_CP_EN_HI:`RFSC_CP_EN_LO];
	assign charge_pump_stage_en   = (charge_pump_cal_enable != 2'b00);
	// current scales as 2^(code/4); code used as stored
	assign charge_pump_code       = synth_charge_pump_cal_reg[`RFSC_CP_CODE_HI:`RFSC_CP_CODE_LO];
	assign vco_high_select        = synth_vco_cal_reg[`RFSC_VCO_HSEL];
	assign vco_current_code       = synth_vco_cal_reg[`RFSC_VCO_CODE_HI:`RFSC_VCO_CODE_LO];
endmodule // rfsc_cal_regs
`default_nettype wire

// *** hdl/rfsc_regs.vh ***
`ifndef RFSC_REGS_VH
`define RFSC_REGS_VH
// ----------------------------------------
// bus geometry
// ----------------------------------------
`define RFSC_ADDR_W       18
`define RFSC_DATA_W       32
`define RFSC_RESP_OKAY    2'b00
`define RFSC_RESP_SLVERR  2'b10
// ----------------------------------------
// register indices, byte address = 4 x index
// ----------------------------------------
`define RFSC_IDX_RX_FE    16'hdf1a
`define RFSC_IDX_TX_FE    16'hdf1b
`define RFSC_IDX_CP_CAL   16'hdf1c
`define RFSC_IDX_VCO_CAL  16'hdf1d
// ----------------------------------------
// register select codes
// ----------------------------------------
`define RFSC_SEL_RX_FE    2'b00
`define RFSC_SEL_TX_FE    2'b01
`define RFSC_SEL_CP_CAL   2'b10
`define RFSC_SEL_VCO_CAL  2'b11
// ----------------------------------------
// reset values
// ----------------------------------------
`define RFSC_RST_RX_FE    8'h56
`define RFSC_RST_TX_FE    8'h10
`define RFSC_RST_CP_CAL   8'ha9
`define RFSC_RST_VCO_CAL  8'h0a
// ----------------------------------------
// field positions
// ----------------------------------------
`define RFSC_RX_LNA_HI    7
`define RFSC_RX_LNA_LO    6
`define RFSC_RX_L2M_HI    5
`define RFSC_RX_L2M_LO    4
`define RFSC_RX_LO_HI     3
`define RFSC_RX_LO_LO     2
`define RFSC_RX_MIX_HI    1
`define RFSC_RX_MIX_LO    0
`define RFSC_TX_LO_HI     5
`define RFSC_TX_LO_LO     4
`define RFSC_TX_RSV_HI    2
`define RFSC_TX_RSV_LO    0
`define RFSC_CP_CFG_HI    7
`define RFSC_CP_CFG_LO    6
`define RFSC_CP_EN_HI     5
`define RFSC_CP_EN_LO     4
`define RFSC_CP_CODE_HI   3
`define RFSC_CP_CODE_LO   0
`define RFSC_VCO_HSEL     5
`define RFSC_VCO_CODE_HI  4
`define RFSC_VCO_CODE_LO  0
// ----------------------------------------
// power resume modes
// ----------------------------------------
`define RFSC_MODE_ACTIVE  2'b00
`define RFSC_MODE_IDLE    2'b01
`define RFSC_MODE_SLEEP_A 2'b10
`define RFSC_MODE_SLEEP_B 2'b11
`endif

// *** hdl/rfsc_axil_slave.v ***
`timescale 1ns/1ps
`default_nettype none
`include "rfsc_regs.vh"
module rfsc_axil_slave (
	input  wire                     aclk,
	input  wire                     aresetn,
	input  wire [`RFSC_ADDR_W-1:0]  s_axi_awaddr,
	input  wire                     s_axi_awvalid,
	output wire                     s_axi_awready,
	input  wire [`RFSC_DATA_W-1:0]  s_axi_wdata,
	input  wire [3:0]               s_axi_wstrb,
	input  wire                     s_axi_wvalid,
	output wire                     s_axi_wready,
	output reg  [1:0]               s_axi_bresp,
	output reg                      s_axi_bvalid,
	input  wire                     s_axi_bready,
	input  wire [`RFSC_ADDR_W-1:0]  s_axi_araddr,
	input  wire                     s_axi_arvalid,
	output wire                     s_axi_arready,
	output reg  [`RFSC_DATA_W-1:0]  s_axi_rdata,
	output reg  [1:0]               s_axi_rresp,
	output reg                      s_axi_rvalid,
	input  wire                     s_axi_rready,
	output wire                     wr_en,
	output wire [`RFSC_ADDR_W-1:0]  wr_addr,
	output wire [7:0]               wr_data,
	output wire                     wr_strb,
	input  wire                     wr_ok,
	output wire [`RFSC_ADDR_W-1:0]  rd_addr,
	input  wire [7:0]               rd_data,
	input  wire                     rd_ok
);
	reg                     aw_held_reg;
	reg                     w_held_reg;
	reg [`RFSC_ADDR_W-1:0]  awaddr_reg;
	reg [7:0]               wdata_reg;
	reg                     wstrb_reg;
	wire                    ar_take;

	// ----------------------------------------
	// write channel
	// ----------------------------------------
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
	assign wr_en         = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign wr_addr       = awaddr_reg;
	assign wr_data       = wdata_reg;
	assign wr_strb       = wstrb_reg;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg  <= 1'b0;
			w_held_reg   <= 1'b0;
			awaddr_reg   <= {`RFSC_ADDR_W{1'b0}};
			wdata_reg    <= 8'h00;
			wstrb_reg    <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RFSC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata[7:0];
				wstrb_reg  <= s_axi_wstrb[0];
			end
			if (wr_en) begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `RFSC_RESP_OKAY : `RFSC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	assign s_axi_arready = !s_axi_rvalid;
	assign ar_take       = s_axi_arvalid && s_axi_arready;
	assign rd_addr       = s_axi_araddr;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= {`RFSC_DATA_W{1'b0}};
			s_axi_rresp  <= `RFSC_RESP_OKAY;
		end else if (ar_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h000000, rd_data};
			s_axi_rresp  <= rd_ok ? `RFSC_RESP_OKAY : `RFSC_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // rfsc_axil_slave
`default_nettype wire

// *** test/rfsc_cal_regs_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rfsc_regs.vh"
module rfsc_cal_regs_checker (
	input wire logic                    aclk,
	input wire logic                    aresetn,
	input wire logic [`RFSC_ADDR_W-1:0] s_axi_araddr,
	input wire logic                    s_axi_arvalid,
	input wire logic                    s_axi_arready,
	input wire logic [`RFSC_DATA_W-1:0] s_axi_rdata,
	input wire logic                    s_axi_rvalid,
	input wire logic                    s_axi_bvalid,
	input wire logic                    cal_done,
	input wire logic [3:0]              cal_charge_pump_code,
	input wire logic [4:0]              cal_vco_code,
	input wire logic                    power_resume,
	input wire logic [1:0]              power_resume_mode,
	input wire logic [1:0]              low_noise_amp_bias,
	input wire logic [1:0]              amp_to_mixer_bias,
	input wire logic [1:0]              rx_lo_buffer_bias,
	input wire logic [1:0]              mixer_bias,
	input wire logic [1:0]              tx_lo_buffer_bias,
	input wire logic [2:0]              tx_reserved_cfg,
	input wire logic [1:0]              synth_cal_config,
	input wire logic [1:0]              charge_pump_cal_enable,
	input wire logic                    charge_pump_stage_en,
	input wire logic [3:0]              charge_pump_code,
	input wire logic                    vco_high_select,
	input wire logic [4:0]              vco_current_code
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----------------------------------------
	// read address tracking
	// ----------------------------------------
	logic [`RFSC_ADDR_W-1:0] rd_addr_reg;
	logic                    deep_resume;
	assign deep_resume = power_resume && power_resume_mode[1];
	always_ff @(posedge aclk) begin
		if (!aresetn)
			rd_addr_reg <= '0;
		else if (s_axi_arvalid && s_axi_arready)
			rd_addr_reg <= s_axi_araddr;
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_vco_cal;
		cal_done && !deep_resume |=> vco_current_code == $past(cal_vco_code);
	endproperty
	a_vco_cal: assert property (p_vco_cal)
		else $error("vco code not loaded");
	property p_cp_cal;
		cal_done && charge_pump_cal_enable != 2'b00 && !deep_resume |=> charge_pump_code == $past(cal_charge_pump_code);
	endproperty
	a_cp_cal: assert property (p_cp_cal)
		else $error("charge pump code not loaded");
	property p_cp_skip;
		cal_done && charge_pump_cal_enable == 2'b00 && !deep_resume |=> $stable(charge_pump_code)
			|| $rose(s_axi_bvalid);
	endproperty
	a_cp_skip: assert property (p_cp_skip)
		else $error("skipped stage changed code");
	property p_resume;
		deep_resume |=> {synth_cal_config, charge_pump_cal_enable, charge_pump_code} == 8'ha9
			&& {vco_high_select, vco_current_code} == 6'h0a;
	endproperty
	a_resume: assert property (p_resume)
		else $error("cal registers not reset on resume");
	property p_stage;
		charge_pump_stage_en == (charge_pump_cal_enable != 2'b00);
	endproperty
	a_stage: assert property (p_stage)
		else $error("stage enable mismatch");
	property p_front_hold;
		$past(aresetn) && !$rose(s_axi_bvalid) |-> $stable({low_noise_amp_bias, amp_to_mixer_bias,
			rx_lo_buffer_bias, mixer_bias, tx_lo_buffer_bias, tx_reserved_cfg});
	endproperty
	a_front_hold: assert property (p_front_hold)
		else $error("front end trim changed without write");
	property p_rx_read;
		$rose(s_axi_rvalid) && rd_addr_reg == 18'h37c68 && !$rose(s_axi_bvalid) |->
			s_axi_rdata[7:0] == {low_noise_amp_bias, amp_to_mixer_bias, rx_lo_buffer_bias, mixer_bias};
	endproperty
	a_rx_read: assert property (p_rx_read)
		else $error("rx config readback mismatch");
	property p_read_zero;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0
			&& (rd_addr_reg != 18'h37c6c || (s_axi_rdata[7:6] == 2'b00 && !s_axi_rdata[3]))
			&& (rd_addr_reg != 18'h37c74 || s_axi_rdata[7:6] == 2'b00);
	endproperty
	a_read_zero: assert property (p_read_zero)
		else $error("unused bits not zero");
endmodule // rfsc_cal_regs_checker
bind rfsc_cal_regs rfsc_cal_regs_checker i_chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_bvalid(s_axi_bvalid), .cal_done(cal_done), .cal_charge_pump_code(cal_charge_pump_code),
	.cal_vco_code(cal_vco_code), .power_resume(power_resume), .power_resume_mode(power_resume_mode),
	.low_noise_amp_bias(low_noise_amp_bias), .amp_to_mixer_bias(amp_to_mixer_bias),
	.rx_lo_buffer_bias(rx_lo_buffer_bias), .mixer_bias(mixer_bias), .tx_lo_buffer_bias(tx_lo_buffer_bias),
	.tx_reserved_cfg(tx_reserved_cfg), .synth_cal_config(synth_cal_config),
	.charge_pump_cal_enable(charge_pump_cal_enable), .charge_pump_stage_en(charge_pump_stage_en),
	.charge_pump_code(charge_pump_code), .vco_high_select(vco_high_select), .vco_current_code(vco_current_code)
);
`default_nettype wire

// *** test/test_radio_frontend_synth_cal_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rfsc_regs.vh"
module test_radio_frontend_synth_cal_regs;
	localparam logic [17:0] adr_rx = 18'h37c68;
	localparam logic [17:0] adr_tx = 18'h37c6c;
	localparam logic [17:0] adr_cp = 18'h37c70;
	localparam logic [17:0] adr_vco = 18'h37c74;
	localparam logic [1:0]  ok = 2'b00;
	localparam logic [1:0]  err = 2'b10;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [17:0] awaddr = 18'h0, araddr = 18'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0]  wstrb = 4'h0, cp_in = 4'h0, cpc;
	logic [4:0]  vco_in = 5'h0, vcc;
	logic [1:0]  bresp, rresp, pmode = 2'b00;
	logic [1:0]  lna, l2m, rxlo, mix, txlo, cfg, cpen;
	logic [2:0]  txrsv;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, stage, vhs;
	logic        cal = 1'b0, pres = 1'b0;
	int          error_cnt = 0;
	int          checked = 0;

	always #2 aclk = ~aclk;

	rfsc_cal_regs i_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cal_done(cal),
		.cal_charge_pump_code(cp_in), .cal_vco_code(vco_in), .power_resume(pres), .power_resume_mode(pmode),
		.low_noise_amp_bias(lna), .amp_to_mixer_bias(l2m), .rx_lo_buffer_bias(rxlo), .mixer_bias(mix),
		.tx_lo_buffer_bias(txlo), .tx_reserved_cfg(txrsv), .synth_cal_config(cfg),
		.charge_pump_cal_enable(cpen), .charge_pump_stage_en(stage), .charge_pump_code(cpc),
		.vco_high_select(vhs), .vco_current_code(vcc)
	);
	// ----------------------------------------
	// common tasks
	// ----------------------------------------
	task summarize;
		if (error_cnt == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task timed_out;
		error_cnt++;
		$display("Error at %0t: bus wait timed out", $time);
		summarize();
	endtask
	task wr(input logic [17:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		bready <= 1'b0;
		if (n == 50)
			timed_out();
		chk(bresp, er);
	endtask
	task rd(input logic [17:0] a, input logic [7:0] exp, input logic [1:0] er);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		rready <= 1'b0;
		if (n == 50)
			timed_out();
		chk(rdata, {24'h0, exp});
		chk(rresp, er);
	endtask
	task pulse(input logic c, input logic [3:0] cc, input logic [4:0] vc, input logic p, input logic [1:0] m);
		@(posedge aclk);
		cal <= c;
		cp_in <= cc;
		vco_in <= vc;
		pres <= p;
		pmode <= m;
		@(posedge aclk);
		cal <= 1'b0;
		pres <= 1'b0;
		#1;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		rd(adr_rx, 8'h56, ok);
		rd(adr_tx, 8'h10, ok);
		rd(adr_cp, 8'ha9, ok);
		rd(adr_vco, 8'h0a, ok);
		chk({stage, vhs, cpc, vcc}, {1'b1, 1'b0, 4'h9, 5'h0a});
	endtask
	task t_access;
		wr(adr_rx, 8'h1b, 4'h1, ok);
		chk({lna, l2m, rxlo, mix}, 8'h1b);
		rd(adr_rx, 8'h1b, ok);
		wr(adr_tx, 8'hff, 4'h1, ok);
		rd(adr_tx, 8'h37, ok);
		wr(adr_tx, 8'h00, 4'h1, ok);
		chk({txlo, txrsv}, 5'h00);
		wr(adr_vco, 8'hff, 4'h1, ok);
		rd(adr_vco, 8'h3f, ok);
		wr(adr_rx, 8'hff, 4'h0, ok);
		wr(18'h37c78, 8'hff, 4'h1, err);
		wr(18'h37c69, 8'hff, 4'h1, err);
		rd(18'h37c78, 8'h00, err);
		rd(adr_rx, 8'h1b, ok);
	endtask
	task t_cal;
		wr(adr_vco, 8'h01, 4'h1, ok);
		wr(adr_cp, 8'h63, 4'h1, ok);
		pulse(1'b1, 4'hc, 5'h15, 1'b0, 2'b00);
		chk({cpc, vcc}, {4'hc, 5'h15});
		rd(adr_cp, 8'h6c, ok);
		rd(adr_vco, 8'h15, ok);
		wr(adr_cp, 8'h43, 4'h1, ok);
		chk(stage, 1'b0);
		pulse(1'b1, 4'he, 5'h07, 1'b0, 2'b00);
		chk({cpc, vcc}, {4'h3, 5'h07});
		wr(adr_cp, 8'hac, 4'h1, ok);
		wr(adr_vco, 8'h15, 4'h1, ok);
		chk({cfg, cpen, stage, cpc, vhs, vcc}, {2'b10, 2'b10, 1'b1, 4'hc, 1'b0, 5'h15});
	endtask
	task t_resume;
		wr(adr_rx, 8'h27, 4'h1, ok);
		wr(adr_tx, 8'h20, 4'h1, ok);
		for (int m = 0; m < 4; m++) begin
			wr(adr_cp, 8'h6c, 4'h1, ok);
			wr(adr_vco, 8'h35, 4'h1, ok);
			pulse(1'b0, 4'h0, 5'h00, 1'b1, m[1:0]);
			chk({cfg, cpen, cpc, vhs, vcc}, (m > 1) ? {8'ha9, 6'h0a} : {8'h6c, 6'h35});
			chk({lna, l2m, rxlo, mix, txlo, txrsv}, {8'h27, 5'h10});
		end
		wr(adr_vco, 8'h35, 4'h1, ok);
		pulse(1'b1, 4'h1, 5'h01, 1'b1, 2'b11);
		chk({cpc, vhs, vcc}, {4'h9, 6'h0a});
	endtask
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_access();
		t_cal();
		t_resume();
		summarize();
	end
endmodule // test_radio_frontend_synth_cal_regs
`default_nettype wire
